// File: inc/uefa_regs.svh
// register offsets, field positions and reset values of the endpoint fifo access block
// assumes a 4-bit register address and 8-bit register data
`ifndef UEFA_REGS_SVH
`define UEFA_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define UEFA_OFS_CTRL   4'h0
`define UEFA_OFS_SEL    4'h1
`define UEFA_OFS_DIRTG  4'h2
`define UEFA_OFS_DATA   4'h3
`define UEFA_OFS_STAT   4'h4
// ----------------------------------------
// field positions
// ----------------------------------------
`define UEFA_CTRL_REQ   0
`define UEFA_CTRL_TX    1
`define UEFA_CTRL_CLR   2
`define UEFA_CTRL_RDY   6
`define UEFA_DIRTG_PID  0
`define UEFA_DIRTG_EP1  1
`define UEFA_DIRTG_EP3  3
// ----------------------------------------
// reset values and widths
// ----------------------------------------
`define UEFA_DIR_RST    3'h7
`define UEFA_PID_RST    1'h0
`define UEFA_UNIMP_W    4
`endif

// File: inc/uefa_pkg.sv
// types shared by the endpoint fifo access block
// assumes 8-bit fifo data and four endpoints
package uefa_pkg;
  // ----------------------------------------
  // data word and buffer fill state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] ep;
    logic       pid;
    logic [7:0] data;
  } uefa_word_t;

  typedef enum logic [2:0] {
    UEFA_BUF_EMPTY = 3'h1,
    UEFA_BUF_ONE   = 3'h2,
    UEFA_BUF_TWO   = 3'h4
  } uefa_buf_t;
endpackage : uefa_pkg

// File: verilog/uefa_endpoint_fifo_access.sv
// endpoint fifo access logic between the core register port and the usb engine
// assumes the usb engine runs on clk and drives its inputs from flip-flops
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "uefa_regs.svh"

module uefa_endpoint_fifo_access
  import uefa_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  input  wire logic       outValid,
  input  wire logic [1:0] outEp,
  input  wire logic [7:0] outData,
  output logic      [3:0] outReady,
  input  wire logic       pktDone,
  input  wire logic [1:0] pktEp,
  output logic      [3:0] epPid,
  input  wire logic       inReq,
  input  wire logic [1:0] inEp,
  output logic            inValid,
  output logic      [7:0] inData,
  output logic      [1:0] inEpOut,
  output logic            inPid,
  input  wire logic       inReady
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // pointer wrap relies on a power-of-two depth
  // the storage index drops the wrap bit of each pointer, so any other depth would alias
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gBadDepth
    $error("DEPTH must be a power of two, at least 2");
  end

  // ----------------------------------------
  // software visible state
  // ----------------------------------------
  logic       request;
  logic       txDir;
  logic       clearCtl;
  logic [1:0] epSel;
  logic [3:1] pipeDir;
  logic       startPid;
  logic [3:0] toggle;

  // decoded strobes
  logic wrCtrl;
  logic wrSel;
  logic wrDirTg;
  logic rdData;
  logic wrData;

  assign wrCtrl  = regWr && (regAddr == `UEFA_OFS_CTRL);
  assign wrSel   = regWr && (regAddr == `UEFA_OFS_SEL);
  assign wrDirTg = regWr && (regAddr == `UEFA_OFS_DIRTG);
  assign wrData  = regWr && (regAddr == `UEFA_OFS_DATA);
  assign rdData  = regRd && (regAddr == `UEFA_OFS_DATA);

  // control bits; clear is level, firmware pulses it high then low
  always_ff @(posedge clk) begin
    if (rst) begin
      request  <= 1'b0;
      txDir    <= 1'b0;
      clearCtl <= 1'b0;
    end else if (wrCtrl) begin
      request  <= regWdata[`UEFA_CTRL_REQ];
      txDir    <= regWdata[`UEFA_CTRL_TX];
      clearCtl <= regWdata[`UEFA_CTRL_CLR];
    end
  end

  // endpoint select
  always_ff @(posedge clk) begin
    if (rst) begin
      epSel <= 2'h0;
    end else if (wrSel) begin
      epSel <= regWdata[1:0];
    end
  end

  // direction and start pid; upper bits are not stored at all
  always_ff @(posedge clk) begin
    if (rst) begin
      pipeDir  <= `UEFA_DIR_RST;
      startPid <= `UEFA_PID_RST;
    end else if (wrDirTg) begin
      pipeDir  <= regWdata[`UEFA_DIRTG_EP3:`UEFA_DIRTG_EP1];
      startPid <= regWdata[`UEFA_DIRTG_PID];
    end
  end

  // ----------------------------------------
  // per endpoint fifos
  // ----------------------------------------
  logic [7:0]  mem [4][DEPTH];
  logic [AW:0] wrPtr [4];
  logic [AW:0] rdPtr [4];
  logic [3:0]  isEmpty;
  logic [3:0]  isFull;
  logic [3:0]  roomTwo;
  logic [3:0]  dirIn;
  logic [3:0]  corePush;
  logic [3:0]  hostPush;
  logic [3:0]  corePop;
  logic [3:0]  bufPop;
  logic [3:0]  clearEp;
  logic        selReady;
  logic        bufAccept;

  // endpoint 0 serves both directions
  assign dirIn = {pipeDir, 1'b1};

  genvar g;
  for (g = 0; g < 4; g++) begin : gEp
    logic [AW:0] used;
    logic [AW:0] limit;
    assign used       = wrPtr[g] - rdPtr[g];
    // two slots kept free: the registered room flag lags one push behind
    assign limit      = (AW+1)'(DEPTH - 2);
    assign isEmpty[g] = (used == '0);
    assign isFull[g]  = (used == (AW+1)'(DEPTH));
    assign roomTwo[g] = (used <= limit);
    assign clearEp[g] = clearCtl && (epSel == 2'(g));
    // core side moves data only while requested and ready
    assign corePush[g] = wrData && selReady && txDir && (epSel == 2'(g));
    assign corePop[g]  = rdData && selReady && !txDir && (epSel == 2'(g));
    // core traffic wins over the usb engine on a shared endpoint
    assign hostPush[g] = outValid && (outEp == 2'(g)) && outReady[g] && !corePush[g];
    assign bufPop[g]   = bufAccept && (inEp == 2'(g)) && !corePop[g];

    // write pointer and storage
    always_ff @(posedge clk) begin
      if (rst || clearEp[g]) begin
        wrPtr[g] <= '0;
      end else if (corePush[g]) begin
        mem[g][wrPtr[g][AW-1:0]] <= regWdata;
        wrPtr[g]                 <= wrPtr[g] + 1'b1;
      end else if (hostPush[g]) begin
        mem[g][wrPtr[g][AW-1:0]] <= outData;
        wrPtr[g]                 <= wrPtr[g] + 1'b1;
      end
    end

    // read pointer
    always_ff @(posedge clk) begin
      if (rst || clearEp[g]) begin
        rdPtr[g] <= '0;
      end else if (corePop[g] || bufPop[g]) begin
        rdPtr[g] <= rdPtr[g] + 1'b1;
      end
    end

    // registered room flag: one push per cycle keeps two free slots safe
    // input pipes never take host bytes; endpoint 0 serves both ways
    always_ff @(posedge clk) begin
      if (rst) begin
        outReady[g] <= 1'b0;
      end else begin
        outReady[g] <= roomTwo[g] && (!dirIn[g] || (g == 0)) && !clearEp[g];
      end
    end

    // data pid tracking, one bit per endpoint
    always_ff @(posedge clk) begin
      if (rst) begin
        toggle[g] <= `UEFA_PID_RST;
      end else if (wrDirTg && request && epSel == 2'(g)) begin
        toggle[g] <= regWdata[`UEFA_DIRTG_PID];
      end else if (pktDone && pktEp == 2'(g)) begin
        toggle[g] <= ~toggle[g];
      end
    end
  end

  // pid outputs straight from flops
  // they trail the per-endpoint toggles by one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      epPid <= '0;
    end else begin
      epPid <= toggle;
    end
  end

  // ----------------------------------------
  // ready indication
  // ----------------------------------------
  // writes need room, reads need data; direction must suit the pipe
  always_comb begin
    selReady = 1'b0;
    if (request && !clearCtl) begin
      if (txDir) begin
        selReady = !isFull[epSel] && dirIn[epSel];
      end else begin
        selReady = !isEmpty[epSel] && (!dirIn[epSel] || epSel == 2'h0);
      end
    end
  end

  // ----------------------------------------
  // two-entry buffer toward the usb engine
  // ----------------------------------------
  uefa_buf_t  bufState;
  uefa_word_t buf0;
  uefa_word_t buf1;
  uefa_word_t fetchWord;
  logic       drain;

  // a full buffer stops fifo reads, so a stalled engine loses nothing
  assign bufAccept = inReq && dirIn[inEp] && !isEmpty[inEp] && !clearEp[inEp]
                     && !corePop[inEp] && (bufState != UEFA_BUF_TWO);
  assign drain     = inValid && inReady;

  always_comb begin
    fetchWord.ep   = inEp;
    fetchWord.pid  = toggle[inEp];
    fetchWord.data = mem[inEp][rdPtr[inEp][AW-1:0]];
  end

  // fill state and entries
  always_ff @(posedge clk) begin
    if (rst) begin
      bufState <= UEFA_BUF_EMPTY;
      buf0     <= '0;
      buf1     <= '0;
    end else begin
      unique case (bufState)
        UEFA_BUF_EMPTY: begin
          if (bufAccept) begin
            buf0     <= fetchWord;
            bufState <= UEFA_BUF_ONE;
          end
        end
        UEFA_BUF_ONE: begin
          if (bufAccept && drain) begin
            buf0 <= fetchWord;
          end else if (bufAccept) begin
            buf1     <= fetchWord;
            bufState <= UEFA_BUF_TWO;
          end else if (drain) begin
            bufState <= UEFA_BUF_EMPTY;
          end
        end
        UEFA_BUF_TWO: begin
          if (drain) begin
            buf0     <= buf1;
            bufState <= UEFA_BUF_ONE;
          end
        end
      endcase
    end
  end

  // outgoing stream mirrors the head entry
  always_ff @(posedge clk) begin
    if (rst) begin
      inValid <= 1'b0;
      inData  <= 8'h00;
      inEpOut <= 2'h0;
      inPid   <= 1'b0;
    end else begin
      unique case (bufState)
        UEFA_BUF_EMPTY: begin
          inValid <= bufAccept;
          inData  <= fetchWord.data;
          inEpOut <= fetchWord.ep;
          inPid   <= fetchWord.pid;
        end
        UEFA_BUF_ONE: begin
          inValid <= !drain || bufAccept;
          if (drain) begin
            inData  <= fetchWord.data;
            inEpOut <= fetchWord.ep;
            inPid   <= fetchWord.pid;
          end
        end
        UEFA_BUF_TWO: begin
          inValid <= 1'b1;
          if (drain) begin
            inData  <= buf1.data;
            inEpOut <= buf1.ep;
            inPid   <= buf1.pid;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  // data stands one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        `UEFA_OFS_CTRL: begin
          regRdata <= {1'b0, selReady, 3'h0, clearCtl, txDir, request};
        end
        `UEFA_OFS_SEL: begin
          regRdata <= {6'h00, epSel};
        end
        `UEFA_OFS_DIRTG: begin
          regRdata <= {`UEFA_UNIMP_W'(0), pipeDir, startPid};
        end
        `UEFA_OFS_DATA: begin
          regRdata <= corePop[epSel] ? mem[epSel][rdPtr[epSel][AW-1:0]] : 8'h00;
        end
        `UEFA_OFS_STAT: begin
          regRdata <= {toggle, isEmpty};
        end
        default: begin
          regRdata <= 8'h00;
        end
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule : uefa_endpoint_fifo_access

// File: sim/uefa_props.sv
// checker for the endpoint fifo access block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`include "uefa_regs.svh"
module uefa_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  input wire logic [3:0] outReady,
  input wire logic       pktDone,
  input wire logic [1:0] pktEp,
  input wire logic [3:0] epPid,
  input wire logic       inValid,
  input wire logic       inReady
);
  logic [2:0] dirS;
  logic [2:0] ctl;
  logic [1:0] selS;
  logic [1:0] pktEpD;
  wire        wrDir = regWr && regAddr == `UEFA_OFS_DIRTG;
  wire        rdDir = regRd && regAddr == `UEFA_OFS_DIRTG;
  wire        rdCtl = regRd && regAddr == `UEFA_OFS_CTRL;
  wire        rdDat = regRd && regAddr == `UEFA_OFS_DATA;
  wire        load  = wrDir && ctl[`UEFA_CTRL_REQ];
  // ----
  // shadows of core writes
  // ----
  // mirrored from the bus so the checker stays blind to the body
  always_ff @(posedge clk) begin
    if (rst) begin
      dirS <= `UEFA_DIR_RST;
      ctl  <= 3'h0;
      selS <= 2'h0;
    end else if (regWr) begin
      if (regAddr == `UEFA_OFS_DIRTG) dirS <= regWdata[3:1];
      if (regAddr == `UEFA_OFS_CTRL) ctl <= regWdata[2:0];
      if (regAddr == `UEFA_OFS_SEL) selS <= regWdata[1:0];
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // packet endpoint one cycle late, to follow the pid output lag
  always_ff @(posedge clk) begin
    pktEpD <= pktEp;
  end
  // ----
  // properties
  // ----
  a_rd_idle: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data not zero");
  a_dir_read: assert property (rdDir |=> regRdata[7:1] == {4'h0, $past(dirS)})
    else $error("direction read back wrong");
  // the room flags are registered, so they follow the direction one cycle late
  a_in_no_room: assert property (($past(dirS) & outReady[3:1]) == 3'h0)
    else $error("room shown on an input pipe");
  // the pid output is one flop behind its toggle, hence the extra cycle
  a_pid_flip: assert property (pktDone && !(load && selS == pktEp)
    |=> ##1 epPid[$past(pktEpD)] != $past(epPid[pktEpD]))
    else $error("data pid did not alternate");
  a_pid_hold: assert property (!pktDone && !load |=> ##1 $stable(epPid))
    else $error("data pid moved without cause");
  a_pid_load: assert property (load
    |=> ##1 epPid[$past(selS, 2)] == $past(regWdata[`UEFA_DIRTG_PID], 2))
    else $error("start pid not loaded");
  a_rdy_req: assert property (rdCtl && (!ctl[0] || ctl[2]) |=> !regRdata[6])
    else $error("ready without request");
  a_data_tx: assert property (rdDat && (ctl[1] || !ctl[0]) |=> regRdata == 8'h00)
    else $error("fifo read while writing");
  c_pkt: cover property (pktDone);
  c_in: cover property (inValid && inReady);
  c_rd_data: cover property (rdDat && ctl[0]);
endmodule : uefa_props

bind uefa_endpoint_fifo_access uefa_props i_props (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .outReady(outReady),
  .pktDone(pktDone), .pktEp(pktEp), .epPid(epPid), .inValid(inValid), .inReady(inReady));

// File: sim/uefa_usb_engine_model.sv
// usb engine model on the stream side of the fifo access block
// assumes the bench calls its tasks at rising clock edges
`timescale 1ns/1ps
module uefa_usb_engine_model
  import uefa_pkg::*;
(
  input  wire logic [3:0] outReady,
  input  wire logic       clk,
  output logic            outValid,
  output logic      [1:0] outEp,
  output logic      [7:0] outData,
  output logic            pktDone,
  output logic      [1:0] pktEp,
  output logic            inReq,
  output logic      [1:0] inEp,
  output logic            inReady
);
  logic       stall;
  logic [1:0] cnt;
  initial begin
    {outValid, outEp, outData, pktDone, pktEp, inReq, inEp, inReady} = '0;
    stall = 1'b0;
    cnt = 2'h0;
  end
  // ready for the head word three cycles in four, never while the bench stalls
  always @(posedge clk) begin
    cnt <= cnt + 2'h1;
    inReady <= !stall && cnt != 2'h0;
  end
  // byte held until the room flag of its endpoint is seen
  task put(input logic [1:0] e, input logic [7:0] d);
    outValid <= 1'b1;
    outEp <= e;
    outData <= d;
    do @(posedge clk); while (outReady[e] !== 1'b1);
  endtask : put
  // stale data would hide a missing valid check
  task idle();
    outValid <= 1'b0;
    outData <= ~outData;
  endtask : idle
  task pkt(input logic [1:0] e);
    @(posedge clk);
    pktDone <= 1'b1;
    pktEp <= e;
    @(posedge clk);
    pktDone <= 1'b0;
  endtask : pkt
endmodule : uefa_usb_engine_model

// File: sim/tb_uefa_endpoint_fifo_access.sv
// self-checking bench for the endpoint fifo access block
// assumes the engine model stands on the stream side
`timescale 1ns/1ps
`include "uefa_regs.svh"
module tb_uefa_endpoint_fifo_access
  import uefa_pkg::*;
;
  logic        clk, rst, regWr, regRd, outValid, pktDone, inReq, inValid, inPid, inReady;
  logic [1:0]  outEp, pktEp, inEp, inEpOut;
  logic [3:0]  regAddr, outReady, epPid;
  logic [7:0]  regWdata, regRdata, outData, inData, d;
  logic [15:0] rdQ[$];
  logic [15:0] e;
  logic [7:0]  q[$];
  uefa_word_t  inQ[$];
  bit          rdP;
  int          miscompares, nChecks;

  uefa_endpoint_fifo_access #(.DEPTH(8)) i_uefa_endpoint_fifo_access (.clk(clk), .rst(rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .outValid(outValid), .outEp(outEp), .outData(outData), .outReady(outReady), .pktDone(pktDone),
    .pktEp(pktEp), .epPid(epPid), .inReq(inReq), .inEp(inEp), .inValid(inValid), .inData(inData),
    .inEpOut(inEpOut), .inPid(inPid), .inReady(inReady));
  uefa_usb_engine_model m (.clk(clk), .outReady(outReady), .outValid(outValid), .outEp(outEp),
    .outData(outData), .pktDone(pktDone), .pktEp(pktEp), .inReq(inReq), .inEp(inEp), .inReady(inReady));

  initial clk = 1'b0;
  always #50 clk = ~clk;
  // ----
  // helpers
  // ----
  task chk(input string n, input logic [10:0] x, input logic [10:0] g);
    nChecks++;
    if (x !== g) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // register read data under its mask; unknown bits still fail
  task chkRd(input logic [7:0] x, input logic [7:0] g);
    chk("regRdata", 11'(x), 11'(g));
  endtask : chkRd
  // head word of the in stream: endpoint, pid, byte
  task chkWord(input uefa_word_t x, input uefa_word_t g);
    chk("inWord", 11'(x), 11'(g));
  endtask : chkWord
  // one access; a read notes its expected byte and mask
  task bus(input bit w, input logic [3:0] a, input logic [7:0] x, input logic [7:0] k);
    @(posedge clk);
    regAddr <= a;
    regWdata <= x;
    regWr <= w;
    regRd <= !w;
    if (!w) rdQ.push_back({x, k});
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
  endtask : bus
  task results();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // read data stand one cycle only, so they are taken at the edge ending it
  always @(posedge clk) begin
    if (rdP) begin
      e = rdQ.pop_front();
      chkRd(e[15:8] & e[7:0], regRdata & e[7:0]);
    end
    if (inValid === 1'b1 && inReady === 1'b1) chkWord(inQ.pop_front(), {inEpOut, inPid, inData});
    rdP = regRd;
  end
  initial begin
    #400000;
    miscompares++;
    results();
  end
  // ----
  // tests
  // ----
  initial begin
    {regWr, regRd, regAddr, regWdata} = '0;
    rst = 1'b1;
    void'($urandom(14));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(0, `UEFA_OFS_DIRTG, 8'h0e, 8'hff);
    bus(0, `UEFA_OFS_CTRL, 8'h00, 8'hff);
    bus(0, `UEFA_OFS_STAT, 8'h0f, 8'hff);
    bus(0, 4'h9, 8'h00, 8'hff);
    chk("outReady", 11'h1, 11'(outReady));
    bus(1, `UEFA_OFS_DIRTG, 8'hf0, 8'h00);
    bus(0, `UEFA_OFS_DIRTG, 8'h00, 8'hff);
    chk("outReady", 11'hf, 11'(outReady));
    $display("test 1 done");
    // core fills ep1 while the engine stalls
    m.stall <= 1'b1;
    m.inEp <= 2'h1;
    m.inReq <= 1'b1;
    bus(1, `UEFA_OFS_SEL, 8'h01, 8'h00);
    bus(1, `UEFA_OFS_CTRL, 8'h03, 8'h00);
    bus(1, `UEFA_OFS_DIRTG, 8'h0f, 8'h00);
    // the pid output trails its toggle by one flop
    @(posedge clk);
    #1 chk("epPid", 11'h2, 11'(epPid));
    bus(0, `UEFA_OFS_CTRL, 8'h43, 8'hff);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      inQ.push_back({2'h1, 1'b1, d});
      bus(1, `UEFA_OFS_DATA, d, 8'h00);
    end
    bus(1, `UEFA_OFS_CTRL, 8'h01, 8'h00);
    bus(1, `UEFA_OFS_CTRL, 8'h00, 8'h00);
    chk("inValid", 11'h1, 11'(inValid));
    m.stall <= 1'b0;
    repeat (20) @(posedge clk);
    chk("inLeft", 11'h0, 11'(inQ.size()));
    m.inReq <= 1'b0;
    m.pkt(2'h1);
    @(posedge clk);
    #1 chk("epPid", 11'h0, 11'(epPid));
    $display("test 2 done");
    // engine fills ep2 as an output pipe, core drains it
    bus(1, `UEFA_OFS_DIRTG, 8'h0a, 8'h00);
    repeat (2) @(posedge clk);
    chk("outReady", 11'h5, 11'(outReady));
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      q.push_back(d);
      m.put(2'h2, d);
    end
    m.idle();
    bus(0, `UEFA_OFS_STAT, 8'h0b, 8'h0f);
    // a data read without a request gives zero and pops nothing
    bus(0, `UEFA_OFS_DATA, 8'h00, 8'hff);
    bus(1, `UEFA_OFS_SEL, 8'h02, 8'h00);
    bus(1, `UEFA_OFS_CTRL, 8'h03, 8'h00);
    bus(0, `UEFA_OFS_CTRL, 8'h03, 8'hff);
    bus(1, `UEFA_OFS_CTRL, 8'h01, 8'h00);
    bus(0, `UEFA_OFS_CTRL, 8'h41, 8'hff);
    while (q.size() > 0) bus(0, `UEFA_OFS_DATA, q.pop_front(), 8'hff);
    bus(0, `UEFA_OFS_CTRL, 8'h01, 8'hff);
    bus(1, `UEFA_OFS_CTRL, 8'h03, 8'h00);
    bus(1, `UEFA_OFS_CTRL, 8'h00, 8'h00);
    $display("test 3 done");
    // a pulsed clear empties ep2
    m.put(2'h2, 8'h5a);
    m.idle();
    bus(1, `UEFA_OFS_CTRL, 8'h01, 8'h00);
    bus(1, `UEFA_OFS_CTRL, 8'h05, 8'h00);
    bus(1, `UEFA_OFS_CTRL, 8'h01, 8'h00);
    bus(0, `UEFA_OFS_STAT, 8'h0f, 8'h0f);
    bus(0, `UEFA_OFS_CTRL, 8'h01, 8'hff);
    bus(1, `UEFA_OFS_CTRL, 8'h00, 8'h00);
    repeat (2) @(posedge clk);
    $display("test 4 done");
    results();
  end
endmodule : tb_uefa_endpoint_fifo_access
